// [design/sfs_consts.vh]
// constants for the six channel fault supervisor
`ifndef SFS_CONSTS_VH
`define SFS_CONSTS_VH
`define SFS_CLK_HZ            10000000
`define SFS_NUM_CH            6
`define SFS_MASK_US           60
`define SFS_DEGLITCH_US       8
`define SFS_RETRY_PERIOD_MS   10
`define SFS_RETRY_WIDTH_US    68
`define SFS_MASK_CYC          ((`SFS_MASK_US * (`SFS_CLK_HZ / 1000000)))
`define SFS_DEGLITCH_CYC      ((`SFS_DEGLITCH_US * (`SFS_CLK_HZ / 1000000)))
`define SFS_RETRY_PERIOD_CYC  ((`SFS_RETRY_PERIOD_MS * (`SFS_CLK_HZ / 1000)))
`define SFS_RETRY_WIDTH_CYC   ((`SFS_RETRY_WIDTH_US * (`SFS_CLK_HZ / 1000000)))
`define SFS_WORD_W            9
`define SFS_BIT_UV            7
`define SFS_BIT_OV            8
`define SFS_CNT_W             17
`endif

// [design/sfs_sync.v]
// two flip-flop level synchroniser
`timescale 1ns/1ns
module sfs_sync #(
  parameter W = 1
) (
  clk,
  rst_n,
  d,
  q
);
  input  wire         clk;
  input  wire         rst_n;
  input  wire [W-1:0] d;
  output reg  [W-1:0] q;
  reg [W-1:0] meta_reg;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= {W{1'b0}};
      q        <= {W{1'b0}};
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule // sfs_sync

// [design/sfs_channel.v]
// one channel: mask, deglitch, short and open fault, retry pulse
`timescale 1ns/1ns
`include "sfs_consts.vh"
module sfs_channel #(
  parameter RETRY_MODE   = 0,
  parameter MASK_CYC     = `SFS_MASK_CYC,
  parameter DEGLITCH_CYC = `SFS_DEGLITCH_CYC,
  parameter PERIOD_CYC   = `SFS_RETRY_PERIOD_CYC,
  parameter WIDTH_CYC    = `SFS_RETRY_WIDTH_CYC
) (
  clk,
  rst_n,
  cmd_on,
  drain_high,
  batt_fault,
  gate_drive,
  short_fault,
  open_fault
);
  input  wire clk;
  input  wire rst_n;
  input  wire cmd_on;
  input  wire drain_high;
  input  wire batt_fault;
  output reg  gate_drive;
  output reg  short_fault;
  output reg  open_fault;

  localparam [`SFS_CNT_W-1:0] MASK_N   = MASK_CYC[`SFS_CNT_W-1:0];
  localparam [`SFS_CNT_W-1:0] DGL_N    = DEGLITCH_CYC[`SFS_CNT_W-1:0];
  localparam [`SFS_CNT_W-1:0] PERIOD_N = PERIOD_CYC[`SFS_CNT_W-1:0];
  localparam [`SFS_CNT_W-1:0] WIDTH_N  = WIDTH_CYC[`SFS_CNT_W-1:0];

  reg  [`SFS_CNT_W-1:0] mask_reg;
  reg  [`SFS_CNT_W-1:0] dgl_reg;
  reg  [`SFS_CNT_W-1:0] per_reg;
  reg                   gate_d_reg;
  reg                   gate_next;
  wire                  mask_done;
  wire                  pulse_on;

  assign mask_done = (mask_reg == {`SFS_CNT_W{1'b0}});
  assign pulse_on  = (per_reg < WIDTH_N);

  // gate drive selection
  always @* begin
    gate_next = cmd_on & ~batt_fault;
    if (short_fault) begin
      if (RETRY_MODE != 0) begin
        gate_next = gate_next & pulse_on;
      end else begin
        gate_next = 1'b0;
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_drive  <= 1'b0;
      gate_d_reg  <= 1'b0;
      // mask runs after reset so synchroniser start-up values raise no open fault
      mask_reg    <= MASK_N;
      dgl_reg     <= {`SFS_CNT_W{1'b0}};
      per_reg     <= {`SFS_CNT_W{1'b0}};
      short_fault <= 1'b0;
      open_fault  <= 1'b0;
    end else begin
      gate_drive <= gate_next;
      gate_d_reg <= gate_drive;
      // mask restarts on every gate edge
      if (gate_drive != gate_d_reg) begin
        mask_reg <= MASK_N;
      end else if (!mask_done) begin
        mask_reg <= mask_reg - 1'b1;
      end
      // on-state deglitch of over-reference drain
      if (gate_drive && gate_d_reg && mask_done && drain_high) begin
        if (dgl_reg < DGL_N) begin
          dgl_reg <= dgl_reg + 1'b1;
        end
      end else begin
        dgl_reg <= {`SFS_CNT_W{1'b0}};
      end
      if (gate_drive && mask_done && drain_high && (dgl_reg >= DGL_N - 1'b1)) begin
        short_fault <= 1'b1;
      end else if (!cmd_on) begin
        short_fault <= 1'b0;
      end else if ((RETRY_MODE != 0) && gate_drive && gate_d_reg && mask_done
                   && !drain_high) begin
        short_fault <= 1'b0;
      end
      // retry period counter
      if (!short_fault || per_reg >= PERIOD_N - 1'b1) begin
        per_reg <= {`SFS_CNT_W{1'b0}};
      end else begin
        per_reg <= per_reg + 1'b1;
      end
      // off-state open load check
      if (!gate_drive && !gate_d_reg && mask_done) begin
        open_fault <= ~drain_high;
      end else if (gate_drive) begin
        open_fault <= 1'b0;
      end
    end
  end
endmodule // sfs_channel

// [design/sfs_top.v]
// six channel fault supervisor top
// Behaviour
// - gate off-to-on starts channel mask timer; short comparator ignored meanwhile
// - after mask, drain high for deglitch time records short fault, flags
// - short deglitch interval is 8 us
// - latched-off variant forces gate off after short until cleared
// - retry variant replaces gate drive with low-duty periodic pulse
// - retry pulses repeat every 10 ms
// - each retry pulse keeps gate on 68 us
// - retry continues until short gone or commanded off; then auto-clears
// - fault word bits 0 to 5 hold per-channel load faults
// - open load checked only with gate off; mask restarts on turn-off
// - after off mask, drain below reference records open fault, flags
// - over-voltage forces all gates off; resumes when cleared
// - over-voltage sets fault word bit 8 and asserts flag
// - under-voltage sets fault word bit 7
// - battery fault suppresses load fault reporting until it clears
// - battery fault captured only if present at chip-select fall
// - chip-select fall releases flag when no fault remains
`timescale 1ns/1ns
`include "sfs_consts.vh"
module sfs_top #(
  parameter NUM_CH       = `SFS_NUM_CH,
  parameter RETRY_MODE   = 0,
  parameter UV_ENABLE    = 1,
  parameter MASK_CYC     = `SFS_MASK_CYC,
  parameter DEGLITCH_CYC = `SFS_DEGLITCH_CYC,
  parameter PERIOD_CYC   = `SFS_RETRY_PERIOD_CYC,
  parameter WIDTH_CYC    = `SFS_RETRY_WIDTH_CYC
) (
  clk,
  reset_n,
  chan_on,
  drain_sense,
  over_voltage,
  under_voltage,
  chip_select_n,
  gate_drive,
  fault_word,
  fault_flag_n_o,
  fault_flag_n_oe
);
  input  wire                     clk;
  input  wire                     reset_n;
  input  wire [NUM_CH-1:0]        chan_on;
  input  wire [NUM_CH-1:0]        drain_sense;
  input  wire                     over_voltage;
  input  wire                     under_voltage;
  input  wire                     chip_select_n;
  output wire [NUM_CH-1:0]        gate_drive;
  output reg  [`SFS_WORD_W-1:0]   fault_word;
  output wire                     fault_flag_n_o;
  output wire                     fault_flag_n_oe;

  // ************************************************
  // reset release
  // ************************************************
  reg rst_a_reg;
  reg rst_b_reg;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_a_reg <= 1'b0;
      rst_b_reg <= 1'b0;
    end else begin
      rst_a_reg <= 1'b1;
      rst_b_reg <= rst_a_reg;
    end
  end

  // ************************************************
  // input synchronisers
  // ************************************************
  wire [NUM_CH-1:0] drain_s;
  wire [1:0]        batt_s;
  sfs_sync #(.W(NUM_CH)) u_sync_drain (
    .clk   (clk),
    .rst_n (rst_b_reg),
    .d     (drain_sense),
    .q     (drain_s)
  );
  sfs_sync #(.W(2)) u_sync_batt (
    .clk   (clk),
    .rst_n (rst_b_reg),
    .d     ({under_voltage, over_voltage}),
    .q     (batt_s)
  );

  wire ov_now;
  wire uv_now;
  wire batt_fault;
  assign ov_now     = batt_s[0];
  assign uv_now     = (UV_ENABLE != 0) & batt_s[1];
  assign batt_fault = ov_now | uv_now;

  // ************************************************
  // channels
  // ************************************************
  wire [NUM_CH-1:0] short_f;
  wire [NUM_CH-1:0] open_f;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi = gi + 1) begin : g_ch
      sfs_channel #(
        .RETRY_MODE   (RETRY_MODE),
        .MASK_CYC     (MASK_CYC),
        .DEGLITCH_CYC (DEGLITCH_CYC),
        .PERIOD_CYC   (PERIOD_CYC),
        .WIDTH_CYC    (WIDTH_CYC)
      ) u_ch (
        .clk         (clk),
        .rst_n       (rst_b_reg),
        .cmd_on      (chan_on[gi]),
        .drain_high  (drain_s[gi]),
        .batt_fault  (ov_now),
        .gate_drive  (gate_drive[gi]),
        .short_fault (short_f[gi]),
        .open_fault  (open_f[gi])
      );
    end
  endgenerate

  // ************************************************
  // fault word and flag
  // ************************************************
  wire [NUM_CH-1:0] load_f;
  wire              any_now;
  reg               cs_d_reg;
  reg               flag_reg;
  wire              cs_fall;
  assign load_f  = (short_f | open_f) & {NUM_CH{~batt_fault}};
  assign any_now = (|load_f) | batt_fault;
  assign cs_fall = cs_d_reg & ~chip_select_n;

  always @(posedge clk or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      cs_d_reg   <= 1'b1;
      flag_reg   <= 1'b0;
      fault_word <= {`SFS_WORD_W{1'b0}};
    end else begin
      cs_d_reg <= chip_select_n;
      if (any_now) begin
        flag_reg <= 1'b1;
      end else if (cs_fall) begin
        flag_reg <= 1'b0;
      end
      if (cs_fall) begin
        fault_word <= {`SFS_WORD_W{1'b0}};
        fault_word[NUM_CH-1:0]  <= load_f;
        fault_word[`SFS_BIT_UV] <= uv_now;
        fault_word[`SFS_BIT_OV] <= ov_now;
      end
    end
  end

  assign fault_flag_n_o  = 1'b0;
  assign fault_flag_n_oe = flag_reg;
endmodule // sfs_top

// [tb/sfs_properties.sv]
// port checker for the fault supervisor
`timescale 1ns/1ns
module sfs_properties (
  input logic       clk,
  input logic       reset_n,
  input logic [5:0] chan_on,
  input logic [5:0] drain_sense,
  input logic       over_voltage,
  input logic       under_voltage,
  input logic       chip_select_n,
  input logic [5:0] gate_drive,
  input logic [8:0] fault_word,
  input logic       fault_flag_n_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire sh0 = chan_on[0] & drain_sense[0] & ~over_voltage & ~under_voltage;
  wire idle = chan_on == 6'h00 && drain_sense == 6'h3f && !over_voltage && !under_voltage;
  mask_ignore_a: assert property (
    (!over_voltage)[*3] ##0 $rose(chan_on[0]) ##1 sh0[*4] |-> gate_drive[0])
    else $error("gate dropped in mask");
  short_off_a: assert property (
    (!over_voltage)[*3] ##0 $rose(chan_on[0]) ##0 sh0[*8] ##1 sh0[*8] |->
    !gate_drive[0] && fault_flag_n_oe)
    else $error("short not acted on");
  gate_cmd_a: assert property ((gate_drive & ~$past(chan_on)) == 6'h00)
    else $error("gate on without command");
  ov_gates_a: assert property (over_voltage[*5] |-> gate_drive == 6'h00)
    else $error("gate on in over-voltage");
  ov_flag_a: assert property (over_voltage[*5] |-> fault_flag_n_oe)
    else $error("no flag in over-voltage");
  ov_word_a: assert property (
    over_voltage[*5] ##0 $fell(chip_select_n) |=>
    fault_word[8] && fault_word[5:0] == 6'h00)
    else $error("bad word in over-voltage");
  uv_word_a: assert property (
    under_voltage[*5] ##0 $fell(chip_select_n) |=> fault_word[7])
    else $error("under-voltage bit missing");
  gone_word_a: assert property (
    (!over_voltage && !under_voltage)[*5] ##0 $fell(chip_select_n)
    |=> fault_word[8:7] == 2'b00)
    else $error("stale battery bit");
  flag_free_a: assert property (
    idle[*8] ##1 idle[*8] ##0 $fell(chip_select_n) |=> !fault_flag_n_oe)
    else $error("flag not released");
  cover property ($rose(fault_flag_n_oe));
  cover property (over_voltage ##0 $fell(chip_select_n));
  cover property ($fell(gate_drive[0]) ##0 chan_on[0]);
endmodule // sfs_properties
bind sfs_top sfs_properties i_props (.clk(clk), .reset_n(reset_n), .chan_on(chan_on),
  .drain_sense(drain_sense), .over_voltage(over_voltage), .under_voltage(under_voltage),
  .chip_select_n(chip_select_n), .gate_drive(gate_drive), .fault_word(fault_word),
  .fault_flag_n_oe(fault_flag_n_oe));

// [tb/sfs_mcu.sv]
// controller model reading the fault word
`timescale 1ns/1ns
module sfs_mcu (
  input  logic       clk,
  input  logic [8:0] fault_word,
  output logic       chip_select_n
);
  initial chip_select_n = 1'b1;
  // select falls at least five cycles apart
  task automatic read_word(output logic [8:0] w);
    chip_select_n = 1'b0;
    repeat (3) @(posedge clk);
    #10;
    w = fault_word;
    chip_select_n = 1'b1;
    repeat (2) @(posedge clk);
    #10;
  endtask
endmodule // sfs_mcu

// [tb/sfs_top_tb.sv]
// self-checking bench for the fault supervisor
`timescale 1ns/1ns
module sfs_top_tb;
  logic clk, reset_n, over_voltage, under_voltage, chip_select_n, flag_o, flag_oe;
  logic [5:0] chan_on, drain_sense, gate_drive;
  logic [8:0] fault_word, w;
  logic [8:0] exp_q[$];
  int bad_count, num_checks, cyc, d, n_on, n_off;
  localparam int PER = 200;
  localparam int WID = 20;
  logic [5:0] chan_on_r, gate_drive_r;
  logic [8:0] fault_word_r;
  logic flag_r_o, flag_r_oe;
  wire fault_flag_n = flag_oe ? flag_o : 1'b1;
  wire flag_r_n = flag_r_oe ? flag_r_o : 1'b1;
  sfs_top #(.RETRY_MODE(1), .MASK_CYC(6), .DEGLITCH_CYC(3), .PERIOD_CYC(PER), .WIDTH_CYC(WID))
    i_dut_retry (
    .clk(clk), .reset_n(reset_n), .chan_on(chan_on_r), .drain_sense(drain_sense),
    .over_voltage(over_voltage), .under_voltage(under_voltage),
    .chip_select_n(chip_select_n), .gate_drive(gate_drive_r), .fault_word(fault_word_r),
    .fault_flag_n_o(flag_r_o), .fault_flag_n_oe(flag_r_oe));
  sfs_top #(.MASK_CYC(6), .DEGLITCH_CYC(3), .PERIOD_CYC(PER), .WIDTH_CYC(WID)) i_dut (
    .clk(clk), .reset_n(reset_n), .chan_on(chan_on), .drain_sense(drain_sense),
    .over_voltage(over_voltage), .under_voltage(under_voltage),
    .chip_select_n(chip_select_n), .gate_drive(gate_drive), .fault_word(fault_word),
    .fault_flag_n_o(flag_o), .fault_flag_n_oe(flag_oe));
  sfs_mcu i_mcu (.clk(clk), .fault_word(fault_word), .chip_select_n(chip_select_n));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask
  // count cycles until retry channel 1 gate shows level v
  task automatic wait_gate(input logic v, output int n);
    n = 0;
    while (gate_drive_r[1] !== v && n < 1000) begin
      step(1);
      n++;
    end
  endtask
  task automatic chk(input logic [8:0] got, input logic [8:0] want);
    num_checks++;
    if (got !== want) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic rd(input logic [8:0] want, input logic flag);
    exp_q.push_back(want);
    i_mcu.read_word(w);
    chk(w, exp_q.pop_front());
    chk({8'h00, fault_flag_n}, {8'h00, flag});
  endtask
  task automatic complete_run;
    if (bad_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      complete_run;
    end
  end
  initial begin
    reset_n = 1'b0;
    chan_on = 6'h00;
    chan_on_r = 6'h00;
    drain_sense = 6'h3f;
    over_voltage = 1'b0;
    under_voltage = 1'b0;
    d = $urandom(32'h225d7e1d);
    d = 1 + $urandom % 5;
    step(5);
    reset_n = 1'b1;
    step(20);
    rd(9'h000, 1'b1);
    for (int i = 0; i < 6; i++) begin
      chan_on[i] = 1'b1;
      drain_sense[i] = 1'b0;
      step(20);
      rd(9'h000, 1'b1);
      chan_on[i] = 1'b0;
      step(12);
      rd(9'h001 << i, 1'b0);
      drain_sense[i] = 1'b1;
      step(20);
      rd(9'h000, 1'b1);
    end
    chan_on[0] = 1'b1;
    step(4);
    chk({3'h0, gate_drive}, 9'h001);
    step(16);
    chk({3'h0, gate_drive}, 9'h000);
    rd(9'h001, 1'b0);
    chan_on[0] = 1'b0;
    step(2);
    chan_on[0] = 1'b1;
    drain_sense[0] = 1'b0;
    step(12);
    chk({3'h0, gate_drive}, 9'h001);
    rd(9'h000, 1'b1);
    drain_sense[d] = 1'b0;
    step(12);
    over_voltage = 1'b1;
    step(6);
    drain_sense[0] = 1'b1;
    chk({3'h0, gate_drive}, 9'h000);
    rd(9'h100, 1'b0);
    over_voltage = 1'b0;
    step(2);
    drain_sense[0] = 1'b0;
    step(8);
    chk({3'h0, gate_drive}, 9'h001);
    rd(9'h001 << d, 1'b0);
    over_voltage = 1'b1;
    step(4);
    over_voltage = 1'b0;
    step(8);
    rd(9'h001 << d, 1'b0);
    under_voltage = 1'b1;
    step(6);
    rd(9'h080, 1'b0);
    under_voltage = 1'b0;
    chan_on = 6'h00;
    drain_sense = 6'h3f;
    step(20);
    rd(9'h000, 1'b1);
    chk(fault_word_r, 9'h000);
    chan_on_r[1] = 1'b1;
    step(2);
    wait_gate(1'b0, n_on);
    rd(9'h000, 1'b1);
    chk(fault_word_r, 9'h002);
    chk({8'h00, flag_r_n}, 9'h000);
    wait_gate(1'b1, n_off);
    wait_gate(1'b0, n_on);
    chk(9'(n_on), 9'(WID));
    wait_gate(1'b1, n_off);
    chk(9'(n_on + n_off), 9'(PER));
    drain_sense[1] = 1'b0;
    step(PER / 2);
    chk({3'h0, gate_drive_r}, 9'h002);
    rd(9'h002, 1'b0);
    chk(fault_word_r, 9'h000);
    chk({8'h00, flag_r_n}, 9'h001);
    complete_run;
  end
endmodule // sfs_top_tb
